/* File: rtl/ls_pkg.sv */
// shared constants and types for the load/store steering block
package ls_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_BANK      = 8'h00;   // core registers, 16 words
    localparam logic [7:0]  OFF_CTRL      = 8'h40;   // control word
    localparam logic [7:0]  OFF_STATUS    = 8'h44;   // status word
    localparam int          CTRL_PRIV_BIT = 0;       // 1: privileged mode
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int          ST_BUSY_BIT   = 0;       // transfer in progress
    localparam int          ST_ABORT_BIT  = 1;       // last transfer aborted
    localparam int          ST_CYC_LSB    = 4;       // cycles of last transfer
    localparam int          CYC_W         = 4;       // width of cycle count

    // ------------------------------------------------------------
    // datapath constants
    // ------------------------------------------------------------
    localparam logic [3:0]  PC_IDX         = 4'hF;         // program counter slot
    localparam logic [31:0] PC_AHEAD       = 32'h0000_0008; // pc reads 8 ahead
    localparam int          PC_LOAD_CYCLES = 4;            // extra cycles, pc load
    localparam logic [4:0]  FAST_LSL_MAX   = 5'h03;        // free left shifts
    localparam logic [31:0] BANK_RESET     = 32'h0000_0000;

    // offset shift kinds
    typedef enum logic [1:0] {
        SH_LSL = 2'b00,   // shift_left_logical
        SH_LSR = 2'b01,   // shift_right_logical
        SH_ASR = 2'b10,   // shift_right_arith
        SH_ROR = 2'b11    // rotate_right, amount 0 is rotate_right_extend
    } shift_e;

    // one decoded single-transfer instruction
    typedef struct packed {
        logic        load;     // 1: load, 0: store
        logic        is_byte;  // 1: byte, 0: word
        logic        pre;      // 1: pre-indexed
        logic        up;       // 1: add offset
        logic        wb;       // writeback / user-force bit
        logic        imm;      // 1: 12-bit immediate offset
        logic [11:0] imm12;    // immediate offset
        shift_e      sh;       // shift kind of offset_register
        logic [4:0]  sh_amt;   // immediate shift amount
        logic [3:0]  rd;       // destination / source
        logic [3:0]  rn;       // base_register
        logic [3:0]  rm;       // offset_register
    } cmd_s;

    // memory request
    typedef struct packed {
        logic        req;      // transfer cycle
        logic        write;    // 1: store
        logic        user;     // 1: non-privileged access
        logic [31:0] addr;     // byte address
        logic [31:0] wdata;    // store data
    } mem_s;

endpackage : ls_pkg

/* File: rtl/data_steer.sv */
// byte-lane steering for loads and stores
`timescale 1ns/1ps
module data_steer (
    // mode
    input  wire logic        i_big,      // endian_select level
    // store side
    input  wire logic        i_st_byte,  // store a byte
    input  wire logic [31:0] i_src,      // source register value
    // load side
    input  wire logic        i_ld_byte,  // load a byte
    input  wire logic [1:0]  i_ld_off,   // low address bits
    input  wire logic [31:0] i_rdata,    // data bus inputs
    // results
    output logic [31:0]      o_store,    // data bus outputs
    output logic [31:0]      o_load      // register value
);

    // ------------------------------------------------------------
    // steering
    // ------------------------------------------------------------
    logic [1:0]  lane;     // byte lane of addressed byte
    logic [63:0] dbl;      // doubled word for rotation
    logic [31:0] rot;      // word rotated right by 8*offset

    // big-endian counts lanes from the top
    always_comb begin
        lane = i_big ? ~i_ld_off : i_ld_off;
        dbl  = {i_rdata, i_rdata} >> {i_ld_off, 3'b000};
        rot  = dbl[31:0];
        // byte zero-filled, word rotated
        o_load = rot;
        if (i_ld_byte) begin
            o_load = {24'h00_0000, i_rdata[{lane, 3'b000} +: 8]};
        end
        // byte replicated, word untouched
        o_store = i_st_byte ? {4{i_src[7:0]}} : i_src;
    end

endmodule : data_steer

/* File: rtl/ls_unit.sv */
// load/store byte and word transfer unit with register bank
//
// Operation
// - byte when byte bit set, else word
// - endian input selects lane steering
// - little-endian byte load from low lanes, zero-filled
// - byte store replicates low byte four times
// - little-endian unaligned word load rotates byte down
// - big-endian byte load from top lanes
// - big-endian word load rotation by offset
// - word store never rotated
// - pc as base reads instruction plus 8
// - stored pc is instruction plus 8
// - pc low two bits read zero
// - abort restores base register
// - aborted load leaves destination unchanged
// - load one cycle, slow shift adds one
// - load into pc adds four cycles
// - store one cycle, register offset adds one
// - post-index writeback bit forces user access
// - pre-index writeback bit updates base
// - offset shifts: five kinds incl. extend
// - offset is immediate 12 or register
// - up bit adds, else subtracts
// - post-index always writes back base
// - shift amount only from instruction
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module ls_unit #(
    parameter int PC_WAIT = ls_pkg::PC_LOAD_CYCLES  // extra cycles, pc load
) (
    // clock and reset
    input  wire logic          i_clock,      // 50 MHz
    input  wire logic          i_rstn,       // sync reset, active low
    // instruction
    input  wire logic          i_cmd_valid,  // instruction offered
    input  wire ls_pkg::cmd_s  i_cmd,        // decoded instruction
    input  wire logic          i_carry,      // carry flag for extend
    input  wire logic          i_endian_select, // 1: big-endian
    output logic               o_busy,       // transfer in progress
    output logic               o_done,       // one-cycle end pulse
    output logic               o_abort,      // one-cycle abort trap pulse
    // memory
    output ls_pkg::mem_s       o_mem,        // transfer request
    input  wire logic [31:0]   i_mem_rdata,  // load data
    input  wire logic          i_mem_abort,  // data abort
    // register bus
    input  wire logic [7:0]    i_reg_addr,   // byte address
    input  wire logic [31:0]   i_reg_wdata,  // write data
    input  wire logic          i_reg_wr,     // write strobe
    input  wire logic          i_reg_rd,     // read strobe
    output logic [31:0]        o_reg_rdata   // read data, next cycle
);

    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,   // waiting for an instruction
        ST_OFFSET = 2'b01,   // extra offset cycle
        ST_XFER   = 2'b10,   // memory transfer cycle
        ST_PCWAIT = 2'b11    // refill after pc load
    } state_e;

    state_e                  state_reg;     // sequencer state
    ls_pkg::cmd_s            cur_reg;       // instruction in flight
    logic [31:0]             bank_reg [16]; // core registers
    logic [31:0]             base_new_reg;  // modified base
    logic                    wb_reg;        // base to be written
    logic [31:0]             ctrl_reg;      // control word
    logic                    abort_st_reg;  // last transfer aborted
    logic [ls_pkg::CYC_W-1:0] cyc_reg;      // cycles so far
    logic [ls_pkg::CYC_W-1:0] last_cyc_reg; // cycles of last transfer
    logic [2:0]              wait_reg;      // pc refill count
    logic                    busy_reg;      // transfer in progress
    logic                    done_reg;      // end pulse
    logic                    abort_reg;     // abort pulse
    ls_pkg::mem_s            mem_reg;       // memory request
    logic [31:0]             rdata_reg;     // bus read data

    logic                    accept;        // instruction taken
    logic                    extra;         // needs offset cycle
    logic                    pc_dest;       // load into pc in flight
    logic                    finish;        // last cycle of transfer
    logic [31:0]             pc_plus8;      // pc as seen by reads
    logic [31:0]             base_val;      // base value
    logic [31:0]             off_val;       // offset value
    logic [31:0]             idx_addr;      // base +/- offset
    logic [31:0]             src_val;       // store source
    logic [31:0]             st_data;       // steered store word
    logic [31:0]             ld_data;       // steered load word

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // shifted register offset, amount from the instruction only
    function automatic logic [31:0] shift_off(
        input logic [31:0]   v,
        input ls_pkg::shift_e t,
        input logic [4:0]    n,
        input logic          c
    );
        logic [63:0] dbl;
        logic [63:0] sext;
        begin
            dbl  = {v, v} >> n;
            // sign copies shifted in from above; a signed shift inside the
            // unsigned conditional would silently turn logical
            sext = {{32{v[31]}}, v} >> n;
            case (t)
                ls_pkg::SH_LSL: shift_off = v << n;
                ls_pkg::SH_LSR: shift_off = (n == 5'h00) ? 32'h0 : v >> n;
                ls_pkg::SH_ASR: shift_off = (n == 5'h00) ? {32{v[31]}} : sext[31:0];
                ls_pkg::SH_ROR: shift_off = (n == 5'h00) ? {c, v[31:1]} : dbl[31:0];
                default:        shift_off = v;
            endcase
        end
    endfunction : shift_off

    // pc slot never holds low address bits
    function automatic logic [31:0] wr_mask(input logic [3:0] i, input logic [31:0] v);
        begin
            wr_mask = (i == ls_pkg::PC_IDX) ? {v[31:2], 2'b00} : v;
        end
    endfunction : wr_mask

    // ------------------------------------------------------------
    // address and operand calculation
    // ------------------------------------------------------------
    assign accept  = i_cmd_valid && (state_reg == ST_IDLE);
    assign pc_dest = cur_reg.load && (cur_reg.rd == ls_pkg::PC_IDX);
    assign finish  = ((state_reg == ST_XFER) && !(pc_dest && !i_mem_abort))
                  || ((state_reg == ST_PCWAIT) && (wait_reg == 3'(PC_WAIT - 1)));

    // operands from the bank, pc as base or source reads 8 ahead, pc as offset register reads raw
    always_comb begin
        pc_plus8 = bank_reg[ls_pkg::PC_IDX] + ls_pkg::PC_AHEAD;
        base_val = (i_cmd.rn == ls_pkg::PC_IDX) ? pc_plus8 : bank_reg[i_cmd.rn];
        src_val  = (i_cmd.rd == ls_pkg::PC_IDX) ? pc_plus8 : bank_reg[i_cmd.rd];
        off_val  = i_cmd.imm ? {20'h0_0000, i_cmd.imm12}
                 : shift_off(bank_reg[i_cmd.rm], i_cmd.sh, i_cmd.sh_amt, i_carry);
        idx_addr = i_cmd.up ? base_val + off_val : base_val - off_val;
        // loads skip the extra cycle for small left shifts
        if (i_cmd.load) begin
            extra = !i_cmd.imm && !((i_cmd.sh == ls_pkg::SH_LSL) &&
                    (i_cmd.sh_amt <= ls_pkg::FAST_LSL_MAX));
        end else begin
            extra = !i_cmd.imm;
        end
    end

    // lane steering
    data_steer u_steer (
        .i_big     (i_endian_select),
        .i_st_byte (i_cmd.is_byte),
        .i_src     (src_val),
        .i_ld_byte (cur_reg.is_byte),
        .i_ld_off  (mem_reg.addr[1:0]),
        .i_rdata   (i_mem_rdata),
        .o_store   (st_data),
        .o_load    (ld_data)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // state walk: idle, optional offset, transfer, optional refill
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE:   if (accept) begin
                    state_reg <= extra ? ST_OFFSET : ST_XFER;
                end
                ST_OFFSET: state_reg <= ST_XFER;
                ST_XFER:   state_reg <= (pc_dest && !i_mem_abort) ? ST_PCWAIT : ST_IDLE;
                ST_PCWAIT: if (wait_reg == 3'(PC_WAIT - 1)) begin
                    state_reg <= ST_IDLE;
                end
                default:   state_reg <= ST_IDLE;
            endcase
        end
    end

    // instruction capture and modified base
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cur_reg      <= '0;
            base_new_reg <= 32'h0;
            wb_reg       <= 1'b0;
        end else if (accept) begin
            cur_reg      <= i_cmd;
            base_new_reg <= idx_addr;
            wb_reg       <= !i_cmd.pre || i_cmd.wb;
        end
    end

    // refill counter after a pc load
    always_ff @(posedge i_clock) begin
        if (!i_rstn || state_reg != ST_PCWAIT) begin
            wait_reg <= 3'h0;
        end else begin
            wait_reg <= wait_reg + 3'h1;
        end
    end

    // cycle count of the transfer
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cyc_reg      <= '0;
            last_cyc_reg <= '0;
        end else if (accept) begin
            cyc_reg <= '0;
        end else if (state_reg != ST_IDLE) begin
            cyc_reg <= cyc_reg + 1'b1;
            if (finish) begin
                last_cyc_reg <= cyc_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // memory request
    // ------------------------------------------------------------
    // request stands for the single transfer cycle
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            mem_reg <= '0;
        end else if (accept) begin
            mem_reg.req   <= !extra;
            mem_reg.write <= !i_cmd.load;
            mem_reg.addr  <= i_cmd.pre ? idx_addr : base_val;
            mem_reg.wdata <= st_data;
            mem_reg.user  <= !ctrl_reg[ls_pkg::CTRL_PRIV_BIT]
                          || (!i_cmd.pre && i_cmd.wb);
        end else if (state_reg == ST_OFFSET) begin
            mem_reg.req <= 1'b1;
        end else begin
            mem_reg.req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    // results land only when no abort; bus writes only while idle
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            for (int i = 0; i < 16; i++) begin
                bank_reg[i] <= ls_pkg::BANK_RESET;
            end
        end else if (state_reg == ST_XFER) begin
            if (!i_mem_abort) begin
                if (wb_reg) begin
                    bank_reg[cur_reg.rn] <= wr_mask(cur_reg.rn, base_new_reg);
                end
                if (cur_reg.load) begin
                    bank_reg[cur_reg.rd] <= wr_mask(cur_reg.rd, ld_data);
                end
            end
        end else if (i_reg_wr && state_reg == ST_IDLE && i_reg_addr < ls_pkg::OFF_CTRL) begin
            bank_reg[i_reg_addr[5:2]] <= wr_mask(i_reg_addr[5:2], i_reg_wdata);
        end
    end

    // ------------------------------------------------------------
    // control, status and pulses
    // ------------------------------------------------------------
    // control word written by software
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            ctrl_reg <= ls_pkg::CTRL_RESET;
        end else if (i_reg_wr && i_reg_addr == ls_pkg::OFF_CTRL) begin
            ctrl_reg <= {31'h0, i_reg_wdata[ls_pkg::CTRL_PRIV_BIT]};
        end
    end

    // busy, done, abort and the abort status
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            abort_reg    <= 1'b0;
            abort_st_reg <= 1'b0;
        end else begin
            busy_reg  <= accept || (busy_reg && !finish);
            done_reg  <= finish;
            abort_reg <= (state_reg == ST_XFER) && i_mem_abort;
            if (state_reg == ST_XFER) begin
                abort_st_reg <= i_mem_abort;
            end
        end
    end

    // bus reads: data in the next cycle only, unmapped read zero
    always_ff @(posedge i_clock) begin
        if (!i_rstn || !i_reg_rd) begin
            rdata_reg <= 32'h0;
        end else if (i_reg_addr < ls_pkg::OFF_CTRL) begin
            rdata_reg <= bank_reg[i_reg_addr[5:2]];
        end else if (i_reg_addr == ls_pkg::OFF_CTRL) begin
            rdata_reg <= ctrl_reg;
        end else if (i_reg_addr == ls_pkg::OFF_STATUS) begin
            rdata_reg <= {24'h0, last_cyc_reg, 2'b00, abort_st_reg, busy_reg};
        end else begin
            rdata_reg <= 32'h0;
        end
    end

    assign o_busy      = busy_reg;
    assign o_done      = done_reg;
    assign o_abort     = abort_reg;
    assign o_mem       = mem_reg;
    assign o_reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    sequence s_xfer_done;
        o_mem.req ##1 o_done;
    endsequence

    sequence s_offset_xfer;
        !o_mem.req ##1 o_mem.req;
    endsequence

    byte_store_rep_a: assert property (o_mem.req && o_mem.write && cur_reg.is_byte |->
        o_mem.wdata == {4{o_mem.wdata[7:0]}}) else $error("byte store not replicated");
    pc_store_a: assert property (accept && !i_cmd.load && i_cmd.rd == ls_pkg::PC_IDX
        && !i_cmd.is_byte |=> ##[0:1] o_mem.req && o_mem.wdata == $past(pc_plus8))
        else $error("stored pc wrong");
    pc_low_zero_a: assert property (bank_reg[ls_pkg::PC_IDX][1:0] == 2'b00)
        else $error("pc low bits set");
    load_fast_a: assert property (accept && i_cmd.load && !extra
        && i_cmd.rd != ls_pkg::PC_IDX |=> s_xfer_done) else $error("load not one cycle");
    offset_cycle_a: assert property (accept && extra |=> s_offset_xfer)
        else $error("offset cycle missing");
    pc_refill_a: assert property (o_mem.req && pc_dest && !i_mem_abort |=>
        !o_done [*4] ##1 o_done) else $error("pc load not four extra cycles");
    abort_keep_a: assert property (o_mem.req && i_mem_abort |=>
        bank_reg[cur_reg.rn] == $past(bank_reg[cur_reg.rn])
        && bank_reg[cur_reg.rd] == $past(bank_reg[cur_reg.rd]) && o_abort)
        else $error("abort changed registers");
    user_force_a: assert property (o_mem.req && !cur_reg.pre && cur_reg.wb |-> o_mem.user)
        else $error("post-index access not forced user");
    byte_zero_a: assert property (o_mem.req && !o_mem.write && cur_reg.is_byte && !i_mem_abort
        |=> bank_reg[cur_reg.rd][31:8] == 24'h0) else $error("byte load not zero-filled");

endmodule : ls_unit

/* File: verif/mem_model.sv */
// memory system model for the load/store unit
`timescale 1ns/1ps
module mem_model (
    // clock
    input  wire logic         i_clock,
    // request from the unit
    input  wire ls_pkg::mem_s i_mem,
    input  wire logic         i_byte,     // byte transfer in flight
    input  wire logic         i_big,      // endian_select level
    input  wire logic         i_abort_on, // answer with a data abort
    // answer
    output logic [31:0]       o_rdata,
    output logic              o_abort
);
    logic [31:0] mem_reg [16];  // words by address bits 5:2
    logic [31:0] last_reg = 32'h0; // o_rdata of the last cycle
    logic [1:0]  lane;          // lane a byte store may touch
    assign lane = i_big ? ~i_mem.addr[1:0] : i_mem.addr[1:0];
    // data only in a read cycle, else a pattern that changes each cycle
    assign o_rdata = (i_mem.req && !i_mem.write) ? mem_reg[i_mem.addr[5:2]] : ~last_reg;
    assign o_abort = i_mem.req && i_abort_on;
    // an aborted store writes nothing; a byte store writes one lane only
    always @(posedge i_clock) begin
        last_reg <= o_rdata;
        if (i_mem.req && i_mem.write && !i_abort_on) begin
            for (int k = 0; k < 4; k++) begin
                if (!i_byte || lane == k[1:0]) begin
                    mem_reg[i_mem.addr[5:2]][8*k +: 8] <= i_mem.wdata[8*k +: 8];
                end
            end
        end
    end
endmodule : mem_model

/* File: verif/load_store_byte_word_steering_test.sv */
// self-checking bench for the load/store unit
`timescale 1ns/1ps
module load_store_byte_word_steering_test;
    logic         i_clock, i_rstn, i_cmd_valid, i_carry, i_endian_select;
    logic         i_reg_wr, i_reg_rd, i_mem_abort, mem_byte, abort_on, o_busy, o_done, o_abort;
    ls_pkg::cmd_s i_cmd;
    ls_pkg::mem_s o_mem;
    logic [31:0]  i_mem_rdata, i_reg_wdata, o_reg_rdata;
    logic [7:0]   i_reg_addr;
    logic [31:0]  w = 32'h44332211; // word under test
    int           err_total, compares, cyc, timer;
    // offset shift table: kind, amount, cycles, address
    int           sh_t [6] = '{0, 0, 1, 2, 3, 3};
    int           am_t [6] = '{1, 4, 4, 4, 4, 0};
    int           cy_t [6] = '{1, 2, 2, 2, 2, 2};
    logic [31:0]  ad_t [6] = '{32'h120, 32'h200, 32'h101, 32'h101, 32'h101, 32'h80000108};

    ls_unit dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_carry(i_carry), .i_endian_select(i_endian_select), .o_busy(o_busy), .o_done(o_done),
        .o_abort(o_abort), .o_mem(o_mem), .i_mem_rdata(i_mem_rdata), .i_mem_abort(i_mem_abort),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata));
    mem_model mem (.i_clock(i_clock), .i_mem(o_mem), .i_byte(mem_byte), .i_big(i_endian_select),
        .i_abort_on(abort_on), .o_rdata(i_mem_rdata), .o_abort(i_mem_abort));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clock);
        i_reg_wr    <= 1'b0;
    endtask : reg_wr
    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge i_clock);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clock);
        i_reg_rd   <= 1'b0;
        #1 check(o_reg_rdata, want);
    endtask : reg_rd
    // offer one instruction, count cycles from accept to done
    task automatic run(input ls_pkg::cmd_s c, input logic big);
        @(posedge i_clock);
        i_cmd_valid     <= 1'b1;
        i_cmd           <= c;
        mem_byte        <= c.is_byte;
        i_endian_select <= big;
        @(posedge i_clock);
        i_cmd_valid     <= 1'b0;
        #1 check({31'h0, o_busy}, 32'h1);
        cyc = 0;
        do begin
            @(posedge i_clock);
            #1 cyc++;
        end while (o_done !== 1'b1 && cyc < 20);
    endtask : run
    function automatic ls_pkg::cmd_s mk(input logic ld, b, pre, up, wb, im, input logic [11:0] off,
                                        input int sh, am, input logic [3:0] rd, rn, rm);
        mk = '{ld, b, pre, up, wb, im, off, ls_pkg::shift_e'(sh[1:0]), am[4:0], rd, rn, rm};
    endfunction : mk

    // ----------------------------------------
    // clock, timeout, stimulus
    // ----------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        timer = 0;
        forever @(posedge i_clock) if (++timer > 5000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        {i_rstn, i_cmd_valid, i_reg_wr, i_reg_rd, mem_byte, abort_on, i_endian_select} = '0;
        {i_cmd, i_reg_addr, i_reg_wdata} = '0;
        i_carry = 1'b1;
        repeat (3) @(posedge i_clock);
        i_rstn <= 1'b1;
        reg_rd(8'h04, 32'h0);
        reg_rd(8'h40, 32'h1);
        reg_wr(8'h04, 32'h100);
        reg_wr(8'h08, w);
        reg_wr(8'h10, 32'h10);
        run(mk(0, 0, 1, 1, 0, 1, 12'h0, 0, 0, 4'h2, 4'h1, 4'h0), 1'b0);
        check(32'(cyc), 32'd1);
        check({31'h0, o_mem.user}, 32'h0);
        run(mk(0, 0, 1, 1, 0, 1, 12'h13, 0, 0, 4'h2, 4'h1, 4'h0), 1'b1);
        check(o_mem.wdata, w);
        // byte and word loads at each offset in both endians
        for (int e = 0; e < 2; e++) for (int k = 0; k < 4; k++) begin
            run(mk(1, 1, 1, 1, 0, 1, 12'(k), 0, 0, 4'h3, 4'h1, 4'h0), e[0]);
            check(32'(cyc), 32'd1);
            reg_rd(8'h0C, {24'h0, w[8*(e ? 3-k : k) +: 8]});
            run(mk(1, 0, 1, 1, 0, 1, 12'(k), 0, 0, 4'h3, 4'h1, 4'h0), e[0]);
            reg_rd(8'h0C, (w >> 8*k) | (w << (32-8*k)));
        end
        // byte stores: replicated byte, one lane written
        for (int e = 0; e < 2; e++) begin
            run(mk(0, 1, 1, 1, 0, 1, 12'(1-e), 0, 0, 4'h4, 4'h1, 4'h0), e[0]);
            check(o_mem.wdata, 32'h10101010);
        end
        run(mk(1, 0, 1, 1, 0, 1, 12'h0, 0, 0, 4'h3, 4'h1, 4'h0), 1'b0);
        reg_rd(8'h0C, 32'h10331011);
        // register offset shifts: address and cycle count
        for (int t = 0; t < 6; t++) begin
            run(mk(1, 0, 1, 1, 0, 0, 12'h0, sh_t[t], am_t[t], 4'h3, 4'h1, 4'h4), 1'b0);
            check(o_mem.addr, ad_t[t]);
            check(32'(cyc), 32'(cy_t[t]));
        end
        // subtract with pre-index writeback, then post-index user access
        run(mk(0, 0, 1, 0, 1, 0, 12'h0, 0, 0, 4'h2, 4'h1, 4'h4), 1'b0);
        check(o_mem.addr, 32'hF0);
        check(32'(cyc), 32'd2);
        reg_rd(8'h04, 32'hF0);
        run(mk(1, 0, 0, 1, 1, 1, 12'h8, 0, 0, 4'h3, 4'h1, 4'h0), 1'b0);
        check({31'h0, o_mem.user}, 32'h1);
        reg_rd(8'h04, 32'hF8);
        // aborted load keeps base and destination
        reg_wr(8'h0C, 32'h5A);
        abort_on <= 1'b1;
        run(mk(1, 0, 0, 1, 0, 1, 12'h4, 0, 0, 4'h3, 4'h1, 4'h0), 1'b0);
        check({31'h0, o_abort}, 32'h1);
        abort_on <= 1'b0;
        reg_rd(8'h04, 32'hF8);
        reg_rd(8'h0C, 32'h5A);
        reg_rd(8'h44, 32'h12);
        // program counter as base, source and destination
        reg_wr(8'h3C, 32'h203);
        reg_rd(8'h3C, 32'h200);
        run(mk(0, 0, 1, 1, 0, 1, 12'h0, 0, 0, 4'hF, 4'hF, 4'h0), 1'b0);
        check(o_mem.addr, 32'h208);
        check(o_mem.wdata, 32'h208);
        run(mk(1, 0, 1, 1, 0, 1, 12'h8, 0, 0, 4'hF, 4'h1, 4'h0), 1'b0);
        check(32'(cyc), 32'd5);
        reg_rd(8'h44, 32'h50);
        test_done();
    end
endmodule : load_store_byte_word_steering_test
